// *** hdl/gpc_port.sv ***
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - after reset ordinary pins undriven; afsel, den, pull-down, pull-up all 0
// - debug pins reset with afsel, den and pull-up set to 1
// - power-on and external reset both restore these default configurations
// - one port block, parameterised per port, instantiated once per port, eight times
// - direction 0: pin is input, value bit holds the sampled pad level
// - direction 1: pin is output, value bit drives the pad if den is set
// - value register spans 256 words, address bits 9:2 mask each access
// - data write changes only bits whose address mask bit is 1
// - data read returns bit where mask is 1, zero where it is 0
// - all enabled pin interrupts merge onto one interrupt output
// - edge interrupt stays latched until software clears it
// - sense, both-edge and polarity jointly choose each pin's trigger
// - sense 0 edge, 1 level; both-edge 1; polarity 0 low/fall, 1 high/rise
// - mask bit decides whether pin condition reaches interrupt output
// - raw status ignores mask; masked status shows unmasked conditions only
// - writing 1 to clear bit clears latched status; 0 does nothing
// - afsel set gives the pin to the peripheral, else software controls
// - protected afsel bits written only when unlocked and commit bit is 1
// - commit bits reset 7F on port B, F0 on port C; read-only elsewhere
// - per-pin drive, open-drain, pulls, slew and digital enable settings
// - eight peripheral and four cell ident registers with fixed values
// - bits with no pad ignore writes and read as zero
module gpc_port #(
	parameter int         PORT_INDEX = 0,
	parameter logic [7:0] PIN_MASK   = 8'hFF
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [gpc_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [gpc_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [7:0]            pad_in,
	output logic [7:0]                 pad_out,
	output logic [7:0]                 pad_oe,
	input  wire logic [7:0]            alt_out,
	input  wire logic [7:0]            alt_oe,
	output logic [7:0]                 alt_in,
	output logic [7:0]                 pad_den,
	output logic [7:0]                 pad_pull_up,
	output logic [7:0]                 pad_pull_down,
	output logic [7:0]                 pad_drv_low,
	output logic [7:0]                 pad_drv_mid,
	output logic [7:0]                 pad_drv_high,
	output logic [7:0]                 pad_open_drain,
	output logic [7:0]                 pad_slew_limit,
	output logic                       irq
);
	import gpc_pkg::*;

	// ****************************************
	// port-dependent constants
	// ****************************************
	localparam logic [7:0] PROT = (PORT_INDEX == PORT_B) ? PROT_B :
		(PORT_INDEX == PORT_C) ? PROT_C : 8'h00;
	localparam logic [7:0] CR_INIT = (PORT_INDEX == PORT_B) ? CR_RST_B :
		(PORT_INDEX == PORT_C) ? CR_RST_C : CR_RST;

	typedef struct packed {
		logic [7:0]  dir;
		logic [7:0]  data;
		logic [7:0]  sense;
		logic [7:0]  both;
		logic [7:0]  pol;
		logic [7:0]  mask;
		logic [7:0]  edge_lat;
		logic [7:0]  afsel;
		logic [7:0]  drv_lo;
		logic [7:0]  drv_mid;
		logic [7:0]  drv_hi;
		logic [7:0]  odr;
		logic [7:0]  pur;
		logic [7:0]  pdr;
		logic [7:0]  slr;
		logic [7:0]  den;
		logic [7:0]  cr;
		logic        unlocked;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic [7:0]  prev;
		logic [7:0]  pout;
		logic [7:0]  poe;
		logic        irq;
		logic        awv;
		logic        wv;
		logic [11:0] waddr;
		logic [31:0] wdat;
		logic [3:0]  wstb;
		logic        awrdy;
		logic        wrdy;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arrdy;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} gpc_state_t;

	gpc_state_t s_r;
	gpc_state_t s_nxt;

	// ****************************************
	// outputs straight from the state flops
	// ****************************************
	assign s_axi_awready  = s_r.awrdy;
	assign s_axi_wready   = s_r.wrdy;
	assign s_axi_bvalid   = s_r.bvalid;
	assign s_axi_bresp    = s_r.bresp;
	assign s_axi_arready  = s_r.arrdy;
	assign s_axi_rvalid   = s_r.rvalid;
	assign s_axi_rdata    = s_r.rdata;
	assign s_axi_rresp    = s_r.rresp;
	assign pad_out        = s_r.pout;
	assign pad_oe         = s_r.poe;
	assign alt_in         = s_r.sync2;
	assign pad_den        = s_r.den;
	assign pad_pull_up    = s_r.pur;
	assign pad_pull_down  = s_r.pdr;
	assign pad_drv_low    = s_r.drv_lo;
	assign pad_drv_mid    = s_r.drv_mid;
	assign pad_drv_high   = s_r.drv_hi;
	assign pad_open_drain = s_r.odr;
	assign pad_slew_limit = s_r.slr;
	assign irq            = s_r.irq;

	// ****************************************
	// interrupt conditions
	// ****************************************
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] edge_hit;
	logic [7:0] level_hit;
	logic [7:0] ris;
	logic [7:0] mis;

	// edges compare successive synchronised samples only
	assign rise = s_r.sync2 & ~s_r.prev;
	assign fall = ~s_r.sync2 & s_r.prev;
	// joint choice of trigger per pin
	assign edge_hit = (s_r.both & (rise | fall)) |
		(~s_r.both & s_r.pol & rise) |
		(~s_r.both & ~s_r.pol & fall);
	assign level_hit = ~(s_r.pol ^ s_r.sync2);
	// raw status ignores the mask, masked status does not
	assign ris = PIN_MASK & ((s_r.sense & level_hit) |
		(~s_r.sense & s_r.edge_lat));
	assign mis = ris & s_r.mask;

	// ****************************************
	// read mux
	// ****************************************
	function automatic logic [8:0] rd_byte(input logic [11:0] a,
		input gpc_state_t s, input logic [7:0] r, input logic [7:0] m);
		logic [7:0] v;
		logic       ok;
		logic [3:0] idx;
		v = 8'h00;
		ok = 1'b1;
		idx = 4'h0;
		if (a[11:10] == 2'b00) begin
			// inputs show the pad, outputs the stored value
			v = ((s.dir & s.data) | (~s.dir & s.sync2)) & a[9:2];
		end else if (a >= OFS_ID) begin
			idx = 4'((a - OFS_ID) >> 2);
			if (idx < ID_COUNT) begin
				v = IDENT[{idx, 3'b000} +: 8];
			end else begin
				ok = 1'b0;
			end
		end else begin
			unique case (a)
				OFS_DIR:   v = s.dir;
				OFS_IS:    v = s.sense;
				OFS_IBE:   v = s.both;
				OFS_IEV:   v = s.pol;
				OFS_IM:    v = s.mask;
				OFS_RIS:   v = r;
				OFS_MIS:   v = m;
				OFS_ICR:   v = 8'h00;
				OFS_AFSEL: v = s.afsel;
				OFS_DR2:   v = s.drv_lo;
				OFS_DR4:   v = s.drv_mid;
				OFS_DR8:   v = s.drv_hi;
				OFS_ODR:   v = s.odr;
				OFS_PUR:   v = s.pur;
				OFS_PDR:   v = s.pdr;
				OFS_SLR:   v = s.slr;
				OFS_DEN:   v = s.den;
				OFS_LOCK:  v = {7'h00, ~s.unlocked};
				OFS_CR:    v = s.cr;
				default:   ok = 1'b0;
			endcase
		end
		rd_byte = {ok, v & ((a == OFS_LOCK) ? 8'hFF : PIN_MASK)};
	endfunction

	// ****************************************
	// next state
	// ****************************************
	logic [7:0]  wd;
	logic [7:0]  wm;
	logic [7:0]  afm;
	logic        wr;
	logic        hit;
	logic [8:0]  rb;
	logic [7:0]  clr;

	always_comb begin
		s_nxt = s_r;
		wd = s_r.wdat[7:0];
		wm = PIN_MASK & {8{s_r.wstb[0]}};
		afm = wm & (~PROT | (s_r.cr & {8{s_r.unlocked}}));
		wr = s_r.awv && s_r.wv && !s_r.bvalid;
		hit = 1'b1;
		clr = 8'h00;
		rb = 9'h000;

		// pad sampling chain, first stage read only by the second
		s_nxt.sync1 = pad_in;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;

		// address and data are taken in either order
		if (s_axi_awvalid && s_r.awrdy) begin
			s_nxt.awv = 1'b1;
			s_nxt.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wrdy) begin
			s_nxt.wv = 1'b1;
			s_nxt.wdat = s_axi_wdata;
			s_nxt.wstb = s_axi_wstrb;
		end

		// register write once both halves are held
		if (wr) begin
			s_nxt.awv = 1'b0;
			s_nxt.wv = 1'b0;
			s_nxt.bvalid = 1'b1;
			if (s_r.waddr[11:10] == 2'b00) begin
				wm = wm & s_r.waddr[9:2];
				s_nxt.data = (s_r.data & ~wm) | (wd & wm);
			end else begin
				unique case (s_r.waddr)
					OFS_DIR:   s_nxt.dir = (s_r.dir & ~wm) | (wd & wm);
					OFS_IS:    s_nxt.sense = (s_r.sense & ~wm) | (wd & wm);
					OFS_IBE:   s_nxt.both = (s_r.both & ~wm) | (wd & wm);
					OFS_IEV:   s_nxt.pol = (s_r.pol & ~wm) | (wd & wm);
					OFS_IM:    s_nxt.mask = (s_r.mask & ~wm) | (wd & wm);
					OFS_ICR:   clr = wd & wm;
					OFS_AFSEL: s_nxt.afsel = (s_r.afsel & ~afm) |
						(wd & afm);
					OFS_DR2:   s_nxt.drv_lo = (s_r.drv_lo & ~wm) | (wd & wm);
					OFS_DR4:   s_nxt.drv_mid = (s_r.drv_mid & ~wm) | (wd & wm);
					OFS_DR8:   s_nxt.drv_hi = (s_r.drv_hi & ~wm) | (wd & wm);
					OFS_ODR:   s_nxt.odr = (s_r.odr & ~wm) | (wd & wm);
					OFS_PUR:   s_nxt.pur = (s_r.pur & ~wm) | (wd & wm);
					OFS_PDR:   s_nxt.pdr = (s_r.pdr & ~wm) | (wd & wm);
					OFS_SLR:   s_nxt.slr = (s_r.slr & ~wm) | (wd & wm);
					OFS_DEN:   s_nxt.den = (s_r.den & ~wm) | (wd & wm);
					OFS_LOCK:  s_nxt.unlocked = (s_r.wdat == LOCK_KEY) &&
						(s_r.wstb == 4'hF);
					// only debug pins may change, and only unlocked
					OFS_CR:    s_nxt.cr = s_r.unlocked ?
						((s_r.cr & ~(wm & PROT)) | (wd & wm & PROT)) :
						s_r.cr;
					default:   hit = 1'b0;
				endcase
			end
			s_nxt.bresp = (hit || s_r.waddr >= OFS_ID) ? RESP_OKAY :
				RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.awrdy = !s_nxt.awv && !s_nxt.bvalid;
		s_nxt.wrdy = !s_nxt.wv && !s_nxt.bvalid;

		// read answers at the same edge that takes the address
		if (s_axi_arvalid && s_r.arrdy) begin
			rb = rd_byte(s_axi_araddr, s_r, ris, mis);
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = {24'h00_0000, rb[7:0]};
			s_nxt.rresp = rb[8] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.arrdy = !s_nxt.rvalid;

		// input pins keep capturing the pad level
		s_nxt.data = (s_nxt.data & s_r.dir) | (s_r.sync2 & ~s_r.dir);

		// set wins over a clear in the same cycle
		s_nxt.edge_lat = (s_r.edge_lat & ~clr) | edge_hit;

		// one port line for all unmasked pins
		s_nxt.irq = |mis;

		// pad drive: peripheral or software, open drain pulls low only
		s_nxt.pout = (s_r.afsel & alt_out) | (~s_r.afsel & s_r.data);
		s_nxt.poe = s_r.den & PIN_MASK &
			((s_r.afsel & alt_oe) | (~s_r.afsel & s_r.dir));
		s_nxt.poe = s_nxt.poe & ~(s_r.odr & s_nxt.pout);
		s_nxt.pout = s_nxt.pout & ~s_r.odr;

		// one reset path for power-on and the external pin
		if (reset) begin
			s_nxt = '0;
			// sampling chain keeps running so no false edge follows reset
			s_nxt.sync1 = pad_in;
			s_nxt.sync2 = s_r.sync1;
			s_nxt.prev = s_r.sync2;
			s_nxt.afsel = PROT;
			s_nxt.den = PROT;
			s_nxt.pur = PROT;
			s_nxt.cr = CR_INIT;
			s_nxt.drv_lo = DR2_RST;
		end
	end

	// ****************************************
	// state register, synchronous reset folded above
	// ****************************************
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// *** inc/gpc_pkg.sv ***
`default_nettype none
package gpc_pkg;
	// ****************************************
	// bus geometry
	// ****************************************
	localparam int AW = 12;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_DIR   = 12'h0400;
	localparam logic [11:0] OFS_IS    = 12'h0404;
	localparam logic [11:0] OFS_IBE   = 12'h0408;
	localparam logic [11:0] OFS_IEV   = 12'h040C;
	localparam logic [11:0] OFS_IM    = 12'h0410;
	localparam logic [11:0] OFS_RIS   = 12'h0414;
	localparam logic [11:0] OFS_MIS   = 12'h0418;
	localparam logic [11:0] OFS_ICR   = 12'h041C;
	localparam logic [11:0] OFS_AFSEL = 12'h0420;
	localparam logic [11:0] OFS_DR2   = 12'h0500;
	localparam logic [11:0] OFS_DR4   = 12'h0504;
	localparam logic [11:0] OFS_DR8   = 12'h0508;
	localparam logic [11:0] OFS_ODR   = 12'h050C;
	localparam logic [11:0] OFS_PUR   = 12'h0510;
	localparam logic [11:0] OFS_PDR   = 12'h0514;
	localparam logic [11:0] OFS_SLR   = 12'h0518;
	localparam logic [11:0] OFS_DEN   = 12'h051C;
	localparam logic [11:0] OFS_LOCK  = 12'h0520;
	localparam logic [11:0] OFS_CR    = 12'h0524;
	localparam logic [11:0] OFS_ID    = 12'h0FD0;
	localparam logic [3:0]  ID_COUNT  = 4'h0C;

	// ****************************************
	// reset values and debug pins
	// ****************************************
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam logic [7:0] PROT_B   = 8'h80;
	localparam logic [7:0] PROT_C   = 8'h0F;
	localparam logic [7:0] CR_RST   = 8'hFF;
	localparam logic [7:0] CR_RST_B = 8'h7F;
	localparam logic [7:0] CR_RST_C = 8'hF0;
	localparam logic [7:0] DR2_RST  = 8'hFF;
	// unlock key: arbitrary value
	localparam logic [31:0] LOCK_KEY = 32'h5A5A_1234;
	// ident bytes, eight peripheral then four cell: arbitrary values
	localparam logic [95:0] IDENT = 96'h0C0B_0A09_0807_0605_0403_0201;
endpackage
`default_nettype wire

// *** test/gpc_pads.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// board side of the pads: driver and pulls
// ****************************************
module gpc_pads (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pull_up,
	input  wire logic [7:0] pad_pull_down,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pad_in
);
	logic [7:0] last_r;
	// port drive wins, then pin 7 held high during reset, then board driver, then pulls
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (reset && i == 7) pad_in[i] = 1'b1;
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pad_pull_up[i]) pad_in[i] = 1'b1;
			else if (pad_pull_down[i]) pad_in[i] = 1'b0;
			else pad_in[i] = ~last_r[i]; // floating: never a stable value
		end
	end
	// last level, so a floating pad keeps moving
	always_ff @(posedge clk) begin
		last_r <= pad_in;
	end
endmodule
`default_nettype wire

// *** test/gpc_port_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bus handshake and reset pin-level checks for one port
// ****************************************
module gpc_port_chk #(
	parameter int PORT_INDEX = 0
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  pad_oe,
	input wire logic [7:0]  pad_den,
	input wire logic [7:0]  pad_pull_up,
	input wire logic        irq
);
	import gpc_pkg::*;
	// debug pins of this port come up owned by the debug logic
	localparam logic [7:0] DBG = (PORT_INDEX == PORT_B) ? PROT_B :
		(PORT_INDEX == PORT_C) ? PROT_C : 8'h00;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// first edge after release still shows the reset configuration
	property p_rst_cfg;
		$fell(reset) |-> pad_oe == 8'h00 && pad_den == DBG &&
			pad_pull_up == DBG && !irq;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg)
		else $error("reset pad configuration wrong");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response not held");
	property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_busy: assert property (p_b_busy)
		else $error("write taken while response pending");
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans)
		else $error("write response late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data not held");
	property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_r_drop: assert property (p_r_drop)
		else $error("read response repeated");
	property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar_ans: assert property (p_ar_ans)
		else $error("read response late");
	property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_busy: assert property (p_ar_busy)
		else $error("read taken while response pending");
	// main traffic seen at all
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** test/gpio_port_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpio_port_control_tb;
	import gpc_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        clk, reset, im, e;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq;
	logic [7:0]  pad_in, pad_out, pad_oe, alt_out, alt_oe, pad_den, ext_en;
	logic [7:0]  pad_pull_up, pad_pull_down, ext_val, d, v, m;
	logic [2:0]  md;
	logic [15:0] rnd;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	int          fail_count, comparisons, cyc;
	logic [2:0]  modes [5] = '{3'b001, 3'b000, 3'b010, 3'b101, 3'b100};

	gpc_port #(.PORT_INDEX(PORT_B), .PIN_MASK(8'hFF)) dut (
		.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.alt_out(alt_out), .alt_oe(alt_oe), .alt_in(), .pad_den(pad_den),
		.pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
		.pad_drv_low(), .pad_drv_mid(), .pad_drv_high(),
		.pad_open_drain(), .pad_slew_limit(), .irq(irq)
	);
	gpc_pads u_pads (
		.clk(clk), .reset(reset), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
	);

	// ****************************************
	// clock, watchdog, response monitor
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// a hung handshake ends the run as a failure
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	// each accepted response is checked against the oldest note
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready) cmp(34'(s_axi_bresp), 34'(wq.pop_front()));
	end

	// ****************************************
	// tasks
	// ****************************************
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task cmp(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ready raised only once the answer shows, so the slave must hold it
	task wr(input logic [11:0] a, input logic [31:0] x, input logic [1:0] r = RESP_OKAY);
		wq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r = RESP_OKAY);
		rq.push_back({r, 24'h0000_00, x});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
	endtask
	task do_reset(input int n);
		reset <= 1'b1;
		tick(n);
		reset <= 1'b0;
		tick(3);
		rd(OFS_AFSEL, PROT_B);
		rd(OFS_DEN, PROT_B);
		rd(OFS_PUR, PROT_B);
		rd(OFS_PDR, 8'h00);
		rd(OFS_CR, CR_RST_B);
		rd(OFS_DR2, DR2_RST);
		rd(OFS_DIR, 8'h00);
	endtask
	task chk_irq(input logic x, input logic k);
		rd(OFS_RIS, 8'(x));
		rd(OFS_MIS, 8'(x & k));
		cmp(34'(irq), 34'(x & k));
	endtask
	task end_sim;
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
		{s_axi_wdata, alt_out, alt_oe} = 0;
		s_axi_wstrb = 4'hF;
		ext_en = 8'hFF;
		ext_val = 8'h80;
		rnd = 16'h4BC4; // starts at 19396
		do_reset(12);
		wr(OFS_AFSEL, 8'h01);
		rd(OFS_AFSEL, 8'h81);
		wr(OFS_LOCK, LOCK_KEY);
		rd(OFS_LOCK, 8'h00);
		wr(OFS_CR, 8'hFF);
		rd(OFS_CR, 8'hFF);
		wr(OFS_AFSEL, 8'h01);
		rd(OFS_AFSEL, 8'h01);
		wr(OFS_LOCK, 32'h0000_0000);
		rd(OFS_LOCK, 8'h01);
		wr(OFS_DEN, 8'hFF);
		tick(2);
		cmp(34'(pad_den), 34'(8'hFF));
		do_reset(2);
		// masked data writes against a running copy
		wr(OFS_DIR, 8'hFF);
		wr(OFS_DEN, 8'hFF);
		ext_en <= 8'h00;
		d = 8'h00;
		repeat (6) begin
			{m, v} = rnd;
			rnd = nxt(rnd);
			alt_out <= v;
			alt_oe <= m;
			wr({2'b00, m, 2'b00}, 32'(v));
			d = (d & ~m) | (v & m);
			rd(12'h1FC, d & 8'h7F);
			rd({3'b000, rnd[6:0], 2'b00}, d & {1'b0, rnd[6:0]});
			cmp(34'(pad_out[6:0]), 34'(d[6:0]));
			cmp(34'({pad_out[7], pad_oe}), 34'({alt_out[7], alt_oe[7], 7'h7F}));
		end
		wr(OFS_DIR, 8'h00);
		v = rnd[7:0];
		ext_en <= 8'hFF;
		ext_val <= v;
		tick(4);
		rd(12'h1FC, v & 8'h7F);
		// pin 0 through every trigger mode, mask on or off
		for (int i = 0; i < 5; i++) begin
			md = modes[i];
			im = rnd[0];
			rnd = nxt(rnd);
			wr(OFS_IM, 8'h00);
			ext_val <= 8'h00;
			wr(OFS_IS, 32'(md[2]));
			wr(OFS_IBE, 32'(md[1]));
			wr(OFS_IEV, 32'(md[0]));
			// earlier pin traffic can leave edges latched on any pin
			wr(OFS_ICR, 8'hFF);
			wr(OFS_IM, 32'(im));
			ext_val <= 8'h01;
			tick(4);
			chk_irq(md[2] ? md[0] : md[1] | md[0], im);
			ext_val <= 8'h00;
			tick(4);
			e = md[2] ? ~md[0] : 1'b1;
			wr(OFS_ICR, 8'h00);
			chk_irq(e, im);
			wr(OFS_ICR, 8'h01);
			chk_irq(md[2] & ~md[0], im);
		end
		wr(12'h600, 8'h55, RESP_SLVERR);
		rd(12'h600, 8'h00, RESP_SLVERR);
		for (int i = 0; i < 12; i++) rd(OFS_ID + 12'(4 * i), IDENT[8 * i +: 8]);
		tick(4);
		end_sim();
	end
endmodule

bind gpc_port gpc_port_chk #(.PORT_INDEX(PORT_INDEX)) u_chk (
	.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pad_oe(pad_oe), .pad_den(pad_den),
	.pad_pull_up(pad_pull_up), .irq(irq)
);
`default_nettype wire
